// *** verilog/hfcg_pkg.sv ***
// Package of constants and types for the clock generator and clock gear.
`default_nettype none
package hfcg_pkg;

  // Register addresses on the plain register port.
  localparam logic [11:0] HFCG_ADDR_GEAR = 12'hFCF;
  localparam logic [11:0] HFCG_ADDR_SYS_ONE = 12'hFDC;
  localparam logic [11:0] HFCG_ADDR_SYS_TWO = 12'hFDD;
  localparam logic [11:0] HFCG_ADDR_PORT_FUNC = 12'hF90;
  localparam logic [11:0] HFCG_ADDR_STATUS = 12'hF91;

  // Values after reset.
  localparam logic [1:0] HFCG_GEAR_RST = 2'h0;
  localparam logic [7:0] HFCG_SYS_TWO_RST = 8'h80;
  localparam logic [7:0] HFCG_PORT_FUNC_RST = 8'h00;

  // Field positions.
  localparam int HFCG_SYS_ONE_REF_SEL_BIT = 3;
  localparam int HFCG_SYS_TWO_INT_EN_BIT = 7;
  localparam int HFCG_SYS_TWO_EXT_HI_EN_BIT = 6;
  localparam int HFCG_SYS_TWO_EXT_LO_EN_BIT = 5;
  localparam int HFCG_SYS_TWO_MAIN_SEL_BIT = 4;
  localparam int HFCG_SYS_TWO_IDLE_BIT = 3;
  localparam int HFCG_SYS_TWO_TG_HALT_BIT = 2;
  localparam int HFCG_PORT_FUNC_HI_BIT = 0;
  localparam int HFCG_PORT_FUNC_LO_BIT = 2;

  // Gear codes and the divide exponent each one selects.
  localparam logic [1:0] HFCG_GEAR_DIV4 = 2'h0;
  localparam logic [1:0] HFCG_GEAR_DIV2 = 2'h1;
  localparam logic [1:0] HFCG_GEAR_DIV1 = 2'h2;
  localparam logic [1:0] HFCG_LOG2_DIV4 = 2'h2;
  localparam logic [1:0] HFCG_LOG2_DIV2 = 2'h1;
  localparam logic [1:0] HFCG_LOG2_DIV1 = 2'h0;

  // Resynchronisation of the reference clock, in source clock periods.
  // The new clock pause is 2.5 periods, rounded up to whole ticks.
  localparam real HFCG_OLD_SYNC_PERIODS = 2.0;
  localparam real HFCG_NEW_SYNC_PERIODS = 2.5;
  localparam logic [1:0] HFCG_OLD_SYNC_TICKS =
    2'(int'($ceil(HFCG_OLD_SYNC_PERIODS)));
  localparam logic [1:0] HFCG_NEW_SYNC_TICKS =
    2'(int'($ceil(HFCG_NEW_SYNC_PERIODS)));

  // Register port request from software.
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } hfcg_bus_req_t;

  // Oscillator enables as driven to the oscillator circuits.
  typedef struct packed {
    logic int_high;
    logic ext_high;
    logic ext_low;
  } hfcg_osc_en_t;

  // Oscillator ticks, one cycle per oscillator period.
  typedef struct packed {
    logic int_high;
    logic ext_high;
    logic ext_low;
  } hfcg_osc_tick_t;

  // Pin function of the oscillator pin pairs.
  typedef struct packed {
    logic high_osc_pin_function;
    logic low_osc_pin_function;
  } hfcg_pin_func_t;

  // Reference clock switch states.
  typedef enum logic [1:0] {
    HFCG_REF_STEADY,
    HFCG_REF_SYNC_OLD,
    HFCG_REF_SYNC_NEW
  } hfcg_ref_state_t;

endpackage
`default_nettype wire

// *** verilog/hfcg_rst_sync.sv ***
// Two flip-flop release synchroniser for the active low reset.
`timescale 1ns/1ps
`default_nettype none
module hfcg_rst_sync
  import hfcg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  output logic rst_n_sync
);

  logic meta_q;
  logic sync_q;

  // Assertion is immediate, release waits two edges to avoid metastability.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= 1'b1;
      sync_q <= meta_q;
    end
  end

  assign rst_n_sync = sync_q;

endmodule
`default_nettype wire

// *** verilog/hfcg_tick_div.sv ***
// Tick stream divider by one, two or four.
`timescale 1ns/1ps
`default_nettype none
module hfcg_tick_div
  import hfcg_pkg::*;
#(
  parameter int CNT_W = 2
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_tick,
  input wire logic [1:0] div_log2,
  output logic out_tick
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last_cnt;
  logic out_tick_q;

  // Terminal count is two to the power of the exponent, minus one.
  assign last_cnt = CNT_W'((1 << div_log2) - 1);

  // A shortened divide after a gear change restarts cleanly from zero.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      out_tick_q <= 1'b0;
    end
    else
    begin
      out_tick_q <= 1'b0;
      if (in_tick)
      begin
        if (cnt_q >= last_cnt)
        begin
          cnt_q <= '0;
          out_tick_q <= 1'b1;
        end
        else
        begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  assign out_tick = out_tick_q;

endmodule
`default_nettype wire

// *** verilog/hfcg_clock_gen.sv ***
// Clock generator and clock gear with prohibited combination guard.
`timescale 1ns/1ps
`default_nettype none
module hfcg_clock_gen
  import hfcg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire hfcg_bus_req_t bus_req,
  output logic [7:0] rd_data,
  input wire hfcg_osc_tick_t osc_tick,
  input wire logic stop_mode_enter,
  output hfcg_osc_en_t osc_en,
  output hfcg_pin_func_t pin_func,
  output logic [7:0] port_zero_function_control,
  output logic high_ref_clock_tick,
  output logic gear_tick,
  output logic sys_tick,
  output logic main_sel_active,
  output logic ref_sel_active,
  output logic cpu_idle,
  output logic tg_halt,
  output logic sys_clk_reset_req
);

  logic rst_n;
  logic [1:0] gear_divide_select_q;
  logic ref_sel_q;
  logic int_en_q;
  logic ext_hi_en_q;
  logic ext_lo_en_q;
  logic main_sel_q;
  logic idle_q;
  logic tg_halt_q;
  logic [7:0] port_func_q;
  logic ref_active_q;
  logic main_active_q;
  hfcg_ref_state_t ref_state_q;
  logic [1:0] sync_cnt_q;
  logic ref_tick_q;
  logic sys_tick_q;
  logic reset_req_q;
  logic [7:0] rd_data_q;
  logic wr_gear;
  logic wr_sys_one;
  logic wr_sys_two;
  logic wr_port;
  logic old_tick;
  logic new_tick;
  logic [1:0] gear_log2;
  logic gear_tick_w;
  logic low_div_tick;
  logic hi_pin_func;
  logic fault_all_off;
  logic fault_low_off;
  logic fault_int_off;
  logic fault_ext_off;
  logic fault_pins;
  logic fault_any;
  logic ref_pending;
  logic main_pending;

  // Local reset release through two flip-flops.
  hfcg_rst_sync u_rst_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .rst_n_sync(rst_n)
  );

  // Write strobes decoded from the address.
  always_comb
  begin
    wr_gear = 1'b0;
    wr_sys_one = 1'b0;
    wr_sys_two = 1'b0;
    wr_port = 1'b0;
    if (bus_req.addr == HFCG_ADDR_GEAR)
    begin
      wr_gear = bus_req.wr;
    end
    else if (bus_req.addr == HFCG_ADDR_SYS_ONE)
    begin
      wr_sys_one = bus_req.wr;
    end
    else if (bus_req.addr == HFCG_ADDR_SYS_TWO)
    begin
      wr_sys_two = bus_req.wr;
    end
    else if (bus_req.addr == HFCG_ADDR_PORT_FUNC)
    begin
      wr_port = bus_req.wr;
    end
  end

  // Gear field; software owns it and the reset value selects divide by four.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gear_divide_select_q <= HFCG_GEAR_RST;
    end
    else if (wr_gear)
    begin
      gear_divide_select_q <= bus_req.wdata[1:0];
    end
  end

  // Reference select. A write while slow mode is selected is dropped, since the
  // resynchroniser needs the high clocks that slow mode may have stopped.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_sel_q <= 1'b0;
    end
    else if (wr_sys_one && !main_sel_q)
    begin
      ref_sel_q <= bus_req.wdata[HFCG_SYS_ONE_REF_SEL_BIT];
    end
  end

  // Oscillator enables. Stop entry turns off both external oscillators in
  // hardware and wins over a write in the same cycle.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_en_q <= HFCG_SYS_TWO_RST[HFCG_SYS_TWO_INT_EN_BIT];
      ext_hi_en_q <= HFCG_SYS_TWO_RST[HFCG_SYS_TWO_EXT_HI_EN_BIT];
      ext_lo_en_q <= HFCG_SYS_TWO_RST[HFCG_SYS_TWO_EXT_LO_EN_BIT];
    end
    else if (stop_mode_enter)
    begin
      ext_hi_en_q <= 1'b0;
      ext_lo_en_q <= 1'b0;
    end
    else if (wr_sys_two)
    begin
      int_en_q <= bus_req.wdata[HFCG_SYS_TWO_INT_EN_BIT];
      ext_hi_en_q <= bus_req.wdata[HFCG_SYS_TWO_EXT_HI_EN_BIT];
      ext_lo_en_q <= bus_req.wdata[HFCG_SYS_TWO_EXT_LO_EN_BIT];
    end
  end

  // Main select and the two low power control bits of the same register.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_sel_q <= HFCG_SYS_TWO_RST[HFCG_SYS_TWO_MAIN_SEL_BIT];
      idle_q <= HFCG_SYS_TWO_RST[HFCG_SYS_TWO_IDLE_BIT];
      tg_halt_q <= HFCG_SYS_TWO_RST[HFCG_SYS_TWO_TG_HALT_BIT];
    end
    else if (wr_sys_two)
    begin
      main_sel_q <= bus_req.wdata[HFCG_SYS_TWO_MAIN_SEL_BIT];
      idle_q <= bus_req.wdata[HFCG_SYS_TWO_IDLE_BIT];
      tg_halt_q <= bus_req.wdata[HFCG_SYS_TWO_TG_HALT_BIT];
    end
  end

  // Port function bits; reset returns the pins to ports.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_func_q <= HFCG_PORT_FUNC_RST;
    end
    else if (wr_port)
    begin
      port_func_q <= bus_req.wdata;
    end
  end

  assign hi_pin_func = port_func_q[HFCG_PORT_FUNC_HI_BIT];

  // Ticks of the clock now running as reference and of the one requested.
  assign old_tick = ref_active_q ? osc_tick.ext_high : osc_tick.int_high;
  assign new_tick = ref_sel_q ? osc_tick.ext_high : osc_tick.int_high;
  assign ref_pending = (ref_state_q != HFCG_REF_STEADY);

  // Reference switch: finish two periods of the old clock, then hold the
  // reference still for three ticks of the new one while the two
  // clocks are aligned. No glitch reaches the gear this way.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_state_q <= HFCG_REF_STEADY;
      sync_cnt_q <= 2'h0;
      ref_active_q <= 1'b0;
    end
    else
    begin
      case (ref_state_q)
        HFCG_REF_STEADY:
        begin
          if (ref_sel_q != ref_active_q)
          begin
            ref_state_q <= HFCG_REF_SYNC_OLD;
            sync_cnt_q <= 2'h0;
          end
        end
        HFCG_REF_SYNC_OLD:
        begin
          if (old_tick)
          begin
            if (sync_cnt_q == HFCG_OLD_SYNC_TICKS - 2'h1)
            begin
              ref_state_q <= HFCG_REF_SYNC_NEW;
              sync_cnt_q <= 2'h0;
            end
            else
            begin
              sync_cnt_q <= sync_cnt_q + 2'h1;
            end
          end
        end
        HFCG_REF_SYNC_NEW:
        begin
          if (new_tick)
          begin
            if (sync_cnt_q == HFCG_NEW_SYNC_TICKS - 2'h1)
            begin
              ref_state_q <= HFCG_REF_STEADY;
              ref_active_q <= ref_sel_q;
              sync_cnt_q <= 2'h0;
            end
            else
            begin
              sync_cnt_q <= sync_cnt_q + 2'h1;
            end
          end
        end
        default:
        begin
          ref_state_q <= HFCG_REF_STEADY;
        end
      endcase
    end
  end

  // Reference ticks follow the active source and pause while aligning.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_tick_q <= 1'b0;
    end
    else
    begin
      ref_tick_q <= old_tick && (ref_state_q != HFCG_REF_SYNC_NEW);
    end
  end

  // Reserved gear code falls back to the slowest setting.
  always_comb
  begin
    case (gear_divide_select_q)
      HFCG_GEAR_DIV4: gear_log2 = HFCG_LOG2_DIV4;
      HFCG_GEAR_DIV2: gear_log2 = HFCG_LOG2_DIV2;
      HFCG_GEAR_DIV1: gear_log2 = HFCG_LOG2_DIV1;
      default: gear_log2 = HFCG_LOG2_DIV4;
    endcase
  end

  // Gear divider on the reference tick stream.
  hfcg_tick_div #(
    .CNT_W(2)
  ) u_gear_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_tick(ref_tick_q),
    .div_log2(gear_log2),
    .out_tick(gear_tick_w)
  );

  // Slow mode clock is the low oscillator divided by four.
  hfcg_tick_div #(
    .CNT_W(2)
  ) u_low_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_tick(osc_tick.ext_low),
    .div_log2(HFCG_LOG2_DIV4),
    .out_tick(low_div_tick)
  );

  assign main_pending = (main_sel_q != main_active_q);

  // Main clock switch completes on the first tick of the destination.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_active_q <= 1'b0;
    end
    else if (main_pending)
    begin
      if (main_sel_q ? low_div_tick : gear_tick_w)
      begin
        main_active_q <= main_sel_q;
      end
    end
  end

  // System tick from the source that is actually running.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_tick_q <= 1'b0;
    end
    else
    begin
      sys_tick_q <= main_active_q ? low_div_tick : gear_tick_w;
    end
  end

  // Prohibited combinations. Both the requested and the still running
  // selection are checked, so stopping the old source early also trips.
  assign fault_all_off = !int_en_q && !ext_hi_en_q && !ext_lo_en_q;
  assign fault_low_off = (main_sel_q || main_active_q) && !ext_lo_en_q;
  assign fault_int_off = !int_en_q &&
    ((!main_sel_q && !ref_sel_q) ||
     (!main_active_q && (!ref_active_q || ref_pending)));
  assign fault_ext_off = !ext_hi_en_q &&
    ((!main_sel_q && ref_sel_q) ||
     (!main_active_q && (ref_active_q || ref_pending)));
  assign fault_pins = ext_hi_en_q && !hi_pin_func;
  assign fault_any = fault_all_off || fault_low_off || fault_int_off ||
    fault_ext_off || fault_pins;

  // One registered request toward the system reset logic.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reset_req_q <= 1'b0;
    end
    else
    begin
      reset_req_q <= fault_any;
    end
  end

  // Read data stands in the cycle after the read strobe only.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_q <= 8'h00;
    end
    else
    begin
      rd_data_q <= 8'h00;
      if (bus_req.rd)
      begin
        if (bus_req.addr == HFCG_ADDR_GEAR)
        begin
          rd_data_q <= {6'h00, gear_divide_select_q};
        end
        else if (bus_req.addr == HFCG_ADDR_SYS_ONE)
        begin
          rd_data_q[HFCG_SYS_ONE_REF_SEL_BIT] <= ref_sel_q;
        end
        else if (bus_req.addr == HFCG_ADDR_SYS_TWO)
        begin
          rd_data_q <= {int_en_q, ext_hi_en_q, ext_lo_en_q, main_sel_q,
                        idle_q, tg_halt_q, 2'h0};
        end
        else if (bus_req.addr == HFCG_ADDR_PORT_FUNC)
        begin
          rd_data_q <= port_func_q;
        end
        else if (bus_req.addr == HFCG_ADDR_STATUS)
        begin
          rd_data_q <= {ref_pending, main_pending, ref_active_q,
                        main_active_q, fault_all_off, fault_low_off,
                        fault_int_off || fault_ext_off, fault_pins};
        end
      end
    end
  end

  // Outputs, all from flip-flops.
  assign rd_data = rd_data_q;
  assign osc_en.int_high = int_en_q;
  assign osc_en.ext_high = ext_hi_en_q;
  assign osc_en.ext_low = ext_lo_en_q;
  assign pin_func.high_osc_pin_function = hi_pin_func;
  assign pin_func.low_osc_pin_function = port_func_q[HFCG_PORT_FUNC_LO_BIT];
  assign port_zero_function_control = port_func_q;
  assign high_ref_clock_tick = ref_tick_q;
  assign gear_tick = gear_tick_w;
  assign sys_tick = sys_tick_q;
  assign main_sel_active = main_active_q;
  assign ref_sel_active = ref_active_q;
  assign cpu_idle = idle_q;
  assign tg_halt = tg_halt_q;
  assign sys_clk_reset_req = reset_req_q;

endmodule
`default_nettype wire

// *** testbench/hfcg_clock_gen_checker.sv ***
// Port checker for the clock generator and clock gear.
`timescale 1ns/1ps
`default_nettype none
module hfcg_clock_gen_checker
  import hfcg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire hfcg_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire hfcg_osc_tick_t osc_tick,
  input wire logic stop_mode_enter,
  input wire hfcg_osc_en_t osc_en,
  input wire hfcg_pin_func_t pin_func,
  input wire logic high_ref_clock_tick,
  input wire logic gear_tick,
  input wire logic sys_tick,
  input wire logic main_sel_active,
  input wire logic ref_sel_active,
  input wire logic sys_clk_reset_req
);
  // One clock domain, so clocking and reset are given once here.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // Steps of a gear register read and of a guard fault.
  sequence s_gear_rd;
    bus_req.rd && bus_req.addr == HFCG_ADDR_GEAR;
  endsequence
  sequence s_all_off;
    osc_en == 3'h0;
  endsequence

  property p_gear_rd;
    s_gear_rd |=> rd_data[7:2] == 6'h00;
  endproperty
  a_gear_rd: assert property (p_gear_rd)
    else $error("gear upper bits read nonzero");
  property p_ref_src;
    high_ref_clock_tick |-> ($past(ref_sel_active) ?
      $past(osc_tick.ext_high) : $past(osc_tick.int_high));
  endproperty
  a_ref_src: assert property (p_ref_src)
    else $error("reference tick from wrong source");
  property p_gear_ref;
    gear_tick |-> $past(high_ref_clock_tick);
  endproperty
  a_gear_ref: assert property (p_gear_ref)
    else $error("gear tick without reference tick");
  property p_sys_gear;
    sys_tick && !main_sel_active && !$past(main_sel_active)
      |-> $past(gear_tick);
  endproperty
  a_sys_gear: assert property (p_sys_gear)
    else $error("system tick not from gear tick");
  property p_all_off;
    s_all_off |=> sys_clk_reset_req;
  endproperty
  a_all_off: assert property (p_all_off)
    else $error("all oscillators off without reset");
  property p_low_off;
    main_sel_active && !osc_en.ext_low |=> sys_clk_reset_req;
  endproperty
  a_low_off: assert property (p_low_off)
    else $error("slow clock off without reset");
  property p_int_off;
    !main_sel_active && !ref_sel_active && !osc_en.int_high
      |=> sys_clk_reset_req;
  endproperty
  a_int_off: assert property (p_int_off)
    else $error("internal reference off without reset");
  property p_ext_off;
    !main_sel_active && ref_sel_active && !osc_en.ext_high
      |=> sys_clk_reset_req;
  endproperty
  a_ext_off: assert property (p_ext_off)
    else $error("external reference off without reset");
  property p_pin;
    osc_en.ext_high && !pin_func.high_osc_pin_function
      |=> sys_clk_reset_req;
  endproperty
  a_pin: assert property (p_pin)
    else $error("high oscillator on port pins without reset");
  property p_stop;
    stop_mode_enter |=> !osc_en.ext_high && !osc_en.ext_low;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop entry left an external oscillator on");
  property p_ref_flip;
    $rose(ref_sel_active) |-> $past(osc_tick.ext_high);
  endproperty
  a_ref_flip: assert property (p_ref_flip)
    else $error("reference switch not on a new source tick");
endmodule

bind hfcg_clock_gen hfcg_clock_gen_checker i_hfcg_clock_gen_checker (
  .core_clk(core_clk), .rstn(rstn), .bus_req(bus_req),
  .rd_data(rd_data), .osc_tick(osc_tick),
  .stop_mode_enter(stop_mode_enter), .osc_en(osc_en),
  .pin_func(pin_func), .high_ref_clock_tick(high_ref_clock_tick),
  .gear_tick(gear_tick), .sys_tick(sys_tick),
  .main_sel_active(main_sel_active), .ref_sel_active(ref_sel_active),
  .sys_clk_reset_req(sys_clk_reset_req));
`default_nettype wire

// *** testbench/hfcg_clock_gen_tb.sv ***
// Self-checking bench for the clock generator and clock gear.
`timescale 1ns/1ps
`default_nettype none
module hfcg_clock_gen_tb
  import hfcg_pkg::*;
;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  hfcg_bus_req_t bus_req = '0;
  hfcg_osc_tick_t osc_tick = '0;
  logic stop_mode_enter = 1'b0;
  logic [7:0] rd_data;
  logic [7:0] port_zero_function_control;
  hfcg_osc_en_t osc_en;
  hfcg_pin_func_t pin_func;
  logic high_ref_clock_tick, gear_tick, sys_tick, main_sel_active;
  logic ref_sel_active, cpu_idle, tg_halt, sys_clk_reset_req;
  int errors = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  int k;

  hfcg_clock_gen i_hfcg_clock_gen (
    .core_clk(core_clk), .rstn(rstn), .bus_req(bus_req),
    .rd_data(rd_data), .osc_tick(osc_tick),
    .stop_mode_enter(stop_mode_enter), .osc_en(osc_en),
    .pin_func(pin_func),
    .port_zero_function_control(port_zero_function_control),
    .high_ref_clock_tick(high_ref_clock_tick), .gear_tick(gear_tick),
    .sys_tick(sys_tick), .main_sel_active(main_sel_active),
    .ref_sel_active(ref_sel_active), .cpu_idle(cpu_idle),
    .tg_halt(tg_halt), .sys_clk_reset_req(sys_clk_reset_req));

  // A 50 ns clock.
  always #25 core_clk = ~core_clk;

  // Oscillators tick only while enabled, each at a distinct period so
  // that a wrong source selection shows up in the tick spacing.
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    osc_tick <= '{int_high: osc_en.int_high === 1'b1 && cyc % 2 == 0,
                  ext_high: osc_en.ext_high === 1'b1 && cyc % 3 == 0,
                  ext_low: osc_en.ext_low === 1'b1 && cyc % 5 == 0};
  end

  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // A write leaves one idle cycle so no strobe is assigned twice.
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
    chk("rd_data", rd_data, exp);
  endtask

  // The guard output lags its cause by a cycle; three edges is ample.
  task req_is(input logic exp);
    repeat (3) @(posedge core_clk);
    #1;
    chk("reset_req", 8'(sys_clk_reset_req), 8'(exp));
  endtask

  task wait_act(input bit slow, input logic exp);
    n = 0;
    while ((slow ? main_sel_active : ref_sel_active) !== exp && n < 200)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("active", 8'(slow ? main_sel_active : ref_sel_active), 8'(exp));
  endtask

  // Counts source ticks between output ticks; the first two spans are
  // skipped because the divider phase after a change is not defined.
  task ratio(input bit slow, input int exp);
    int c;
    int j;
    c = 0;
    for (j = 0; j < 3; j++)
    begin
      n = 0;
      c = 0;
      do
      begin
        @(posedge core_clk);
        #1;
        n++;
        c += slow ? int'(osc_tick.ext_low) : int'(high_ref_clock_tick);
      end
      while (!(slow ? sys_tick : gear_tick) && n < 100);
    end
    chk("ratio", 8'(c), 8'(exp));
  endtask

  task give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Whole run takes a few hundred cycles; this cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge core_clk);
    errors++;
    give_verdict();
  end

  // Main sequence of scenarios.
  initial
  begin
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("osc_en", 8'(osc_en), 8'h04);
    chk("ref_active", 8'(ref_sel_active), 8'h00);
    req_is(1'b0);
    rd(HFCG_ADDR_GEAR, 8'h00);
    rd(HFCG_ADDR_SYS_TWO, 8'h80);
    rd(HFCG_ADDR_SYS_ONE, 8'h00);
    rd(HFCG_ADDR_PORT_FUNC, 8'h00);
    wr(12'h000, 8'hFF);
    rd(12'h000, 8'h00);
    for (k = 0; k < 4; k++)
    begin
      wr(HFCG_ADDR_GEAR, 8'hFC | 8'(k));
      rd(HFCG_ADDR_GEAR, 8'(k));
      ratio(1'b0, k == 2 ? 1 : (k == 1 ? 2 : 4));
    end
    wr(HFCG_ADDR_SYS_TWO, 8'h20);
    req_is(1'b1);
    wr(HFCG_ADDR_SYS_TWO, 8'h00);
    req_is(1'b1);
    wr(HFCG_ADDR_SYS_TWO, 8'h90);
    req_is(1'b1);
    // The slow switch waits for a low tick that never comes, so the
    // status shows it pending together with the low-off fault.
    rd(HFCG_ADDR_STATUS, 8'h44);
    @(posedge core_clk);
    #1;
    chk("rd_idle", rd_data, 8'h00);
    wr(HFCG_ADDR_SYS_ONE, 8'h08);
    rd(HFCG_ADDR_SYS_ONE, 8'h00);
    wr(HFCG_ADDR_SYS_TWO, 8'h80);
    req_is(1'b0);
    // The two low power bits are set one at a time, never together.
    wr(HFCG_ADDR_SYS_TWO, 8'h88);
    rd(HFCG_ADDR_SYS_TWO, 8'h88);
    chk("cpu_idle", 8'(cpu_idle), 8'h01);
    wr(HFCG_ADDR_SYS_TWO, 8'h84);
    rd(HFCG_ADDR_SYS_TWO, 8'h84);
    chk("tg_halt", 8'({cpu_idle, tg_halt}), 8'h01);
    wr(HFCG_ADDR_SYS_TWO, 8'h80);
    // Switch the reference to the external source, stopping the old
    // source once in mid-switch.
    wr(HFCG_ADDR_PORT_FUNC, 8'h01);
    wr(HFCG_ADDR_SYS_TWO, 8'hC0);
    req_is(1'b0);
    wr(HFCG_ADDR_SYS_ONE, 8'h08);
    wr(HFCG_ADDR_SYS_TWO, 8'h40);
    req_is(1'b1);
    wr(HFCG_ADDR_SYS_TWO, 8'hC0);
    wait_act(1'b0, 1'b1);
    wr(HFCG_ADDR_GEAR, 8'h01);
    ratio(1'b0, 2);
    wr(HFCG_ADDR_SYS_TWO, 8'h40);
    req_is(1'b0);
    wr(HFCG_ADDR_PORT_FUNC, 8'h00);
    req_is(1'b1);
    wr(HFCG_ADDR_PORT_FUNC, 8'h01);
    wr(HFCG_ADDR_SYS_TWO, 8'h80);
    req_is(1'b1);
    wr(HFCG_ADDR_SYS_TWO, 8'hC0);
    wr(HFCG_ADDR_SYS_ONE, 8'h00);
    wait_act(1'b0, 1'b0);
    wr(HFCG_ADDR_SYS_TWO, 8'h80);
    req_is(1'b0);
    // Slow mode from the low oscillator, then stop entry.
    wr(HFCG_ADDR_PORT_FUNC, 8'h05);
    wr(HFCG_ADDR_SYS_TWO, 8'hA0);
    wr(HFCG_ADDR_SYS_TWO, 8'hB0);
    wait_act(1'b1, 1'b1);
    req_is(1'b0);
    ratio(1'b1, 4);
    @(posedge core_clk);
    stop_mode_enter <= 1'b1;
    @(posedge core_clk);
    stop_mode_enter <= 1'b0;
    rd(HFCG_ADDR_SYS_TWO, 8'h90);
    chk("pin_func", 8'(pin_func), 8'h03);
    chk("port_func", port_zero_function_control, 8'h05);
    req_is(1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
